/* File: core/gio_cell.sv */
// register logic of one general-purpose pad cell between core fabric and pad
`timescale 1ns/1ps
`default_nettype none

// What this block does
// (R1) capture, output and enable registers exist
// (R2) enable register switches pad driver on/off
// (R3) input mode: capture on chosen input edge
// (R4) alternate path passes pad value unregistered
// (R5) alternate path bypasses the core interface
// (R6) double-edge input: two samples, two streams
// (R7) output mode: register on chosen output edge
// (R8) option inverts output value to pad
// (R9) double-edge output muxes two bits onto pad
// (R10) bidir: in clock captures, out clock drives
// (R11) bidir: receive and transmit registering independent
// (R12) clock-output mode drives tree clock onto pad
// (R13) high-speed cell adds 1:4 serdes, full rate
// (R14) weak pull-up while configuring
// (R15) unused pads: driver off, weak pull-up
// (R16) unused pull may become pull-down
// (R17) rising sample bit 0, falling bit 1
// (R18) resync delays falling sample half period
// (R19) enable inactive means driver high impedance
module gio_cell #(
    parameter bit HIGH_SPEED = 1'b1,
    parameter int CW         = gio_pkg::GIO_CORE_WIDTH
) (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                resetn_i,
    // configuration
    input  wire logic                configuring_i,
    input  wire gio_pkg::gio_mode_t  mode_i,
    input  wire logic                in_reg_en_i,
    input  wire logic                in_fall_edge_i,
    input  wire logic                out_reg_en_i,
    input  wire logic                out_fall_edge_i,
    input  wire logic                oe_fall_edge_i,
    input  wire logic                out_invert_i,
    input  wire logic                double_edge_mode_i,
    input  wire logic                ddr_resync_i,
    input  wire logic                serdes_en_i,
    input  wire logic                alt_sel_i,
    input  wire logic                pull_down_sel_i,
    // core clock tree levels
    input  wire logic                in_clk_i,
    input  wire logic                out_clk_i,
    // core side
    input  wire logic [CW-1:0]       core_out_i,
    input  wire logic                core_oe_i,
    output logic [CW-1:0]            core_in_o,
    // alternate pad path
    output logic                     alternate_pad_path_o,
    // pad side
    input  wire logic                pad_i,
    output logic                     pad_o,
    output logic                     pad_oe_o,
    output logic                     pull_up_o,
    output logic                     pull_down_o
);
    // pad synchroniser
    logic            sync1;
    logic            sync2;
    logic            sync3;
    logic            pad_level;
    logic            next_pad_level;
    // clock edge detection
    logic            in_clk_q;
    logic            out_clk_q;
    logic            in_rise;
    logic            in_fall;
    logic            out_rise;
    logic            out_fall;
    logic            cap_edge;
    logic            out_edge;
    logic            oe_edge;
    // mode decode
    logic            rx_active;
    logic            tx_active;
    logic            serdes_rx;
    logic            serdes_tx;
    // data path state
    logic            fall_hold;
    logic            next_fall_hold;
    logic [CW-1:0]   next_core_in;
    logic            tx_data;
    logic            next_tx_data;
    logic            oe_q;
    logic            next_oe_q;
    logic            next_pad;
    logic            next_pad_oe;
    logic            next_pull_up;
    logic            next_pull_down;
    logic [CW-1:0]   deser_word;
    logic            ser_bit;

    // the pad is asynchronous: three stages, a change counts once stages two and three agree
    assign next_pad_level = (sync2 == sync3) ? sync3 : pad_level;

    // input and output clocks arrive as levels; edges become one-cycle enables
    assign in_rise  = in_clk_i & ~in_clk_q;
    assign in_fall  = ~in_clk_i & in_clk_q;
    assign out_rise = out_clk_i & ~out_clk_q;
    assign out_fall = ~out_clk_i & out_clk_q;
    assign cap_edge = in_fall_edge_i ? in_fall : in_rise;           // R3
    assign out_edge = out_fall_edge_i ? out_fall : out_rise;        // R7
    assign oe_edge  = oe_fall_edge_i ? out_fall : out_rise;         // R10

    // receive and transmit decode; serdes only at full rate, never with double edge
    assign rx_active = (mode_i == gio_pkg::GIO_INPUT) || (mode_i == gio_pkg::GIO_BIDIR);
    assign tx_active = (mode_i == gio_pkg::GIO_OUTPUT) || (mode_i == gio_pkg::GIO_BIDIR);
    assign serdes_rx = HIGH_SPEED && serdes_en_i && !double_edge_mode_i;  // R13
    assign serdes_tx = serdes_rx;

    // the alternate path is the pad gated only by alt_sel_i, no register on purpose
    assign alternate_pad_path_o = alt_sel_i & pad_i;                // R4 R5

    gio_serdes #(
        .W (CW)
    ) u_serdes (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .shift_in_i  (rx_active & serdes_rx & in_rise),
        .in_bit_i    (pad_level),
        .par_o       (deser_word),
        .shift_out_i (tx_active & serdes_tx & out_rise),
        .par_i       (core_out_i),
        .ser_o       (ser_bit)
    );

    // receive path: registered, unregistered, double edge or deserialised
    always_comb begin
        next_core_in   = core_in_o;
        next_fall_hold = fall_hold;
        if (rx_active) begin
            if (serdes_rx) begin
                next_core_in = deser_word;                          // R13
            end else if (double_edge_mode_i) begin
                if (in_rise) begin
                    next_core_in[0] = pad_level;                    // R6 R17
                    if (ddr_resync_i) begin
                        next_core_in[1] = fall_hold;                // R18
                    end
                end
                if (in_fall) begin
                    next_fall_hold = pad_level;                     // R18
                    if (!ddr_resync_i) begin
                        next_core_in[1] = pad_level;                // R6 R17
                    end
                end
            end else if (in_reg_en_i) begin
                if (cap_edge) begin
                    next_core_in[0] = pad_level;                    // R1 R3 R11
                end
            end else begin
                next_core_in[0] = pad_level;                        // R11
            end
        end
    end

    // transmit data and enable registers
    always_comb begin
        next_tx_data = tx_data;
        next_oe_q    = oe_q;
        if (mode_i == gio_pkg::GIO_CLKOUT) begin
            next_tx_data = out_clk_i;                               // R12
        end else if (tx_active) begin
            if (serdes_tx) begin
                next_tx_data = ser_bit;                             // R13
            end else if (double_edge_mode_i) begin
                if (out_rise) begin
                    next_tx_data = core_out_i[0];                   // R9
                end else if (out_fall) begin
                    next_tx_data = core_out_i[1];                   // R9
                end
            end else if (out_reg_en_i) begin
                if (out_edge) begin
                    next_tx_data = core_out_i[0];                   // R1 R7 R11
                end
            end else begin
                next_tx_data = core_out_i[0];                       // R11
            end
            // the enable follows the output register setting of the cell
            if (!out_reg_en_i || oe_edge) begin
                next_oe_q = core_oe_i;                              // R1 R10
            end
        end
    end

    // pad driver and weak pulls; configuration overrides everything
    always_comb begin
        next_pad_oe    = 1'b0;
        next_pull_up   = 1'b0;
        next_pull_down = 1'b0;
        if (configuring_i) begin
            next_pull_up = 1'b1;                                    // R14
        end else if (mode_i == gio_pkg::GIO_UNUSED) begin
            next_pull_up   = ~pull_down_sel_i;                      // R15
            next_pull_down = pull_down_sel_i;                       // R16
        end else if (mode_i == gio_pkg::GIO_CLKOUT) begin
            next_pad_oe = 1'b1;                                     // R12
        end else if (tx_active) begin
            next_pad_oe = next_oe_q;                                // R2
        end
        // data is parked low when not driving, so the pad sees only the board
        if (!next_pad_oe) begin
            next_pad = 1'b0;                                        // R19
        end else if (mode_i == gio_pkg::GIO_CLKOUT) begin
            next_pad = next_tx_data;
        end else begin
            next_pad = next_tx_data ^ out_invert_i;                 // R8
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sync1       <= gio_pkg::GIO_RST_DATA;
            sync2       <= gio_pkg::GIO_RST_DATA;
            sync3       <= gio_pkg::GIO_RST_DATA;
            pad_level   <= gio_pkg::GIO_RST_DATA;
            in_clk_q    <= gio_pkg::GIO_RST_DATA;
            out_clk_q   <= gio_pkg::GIO_RST_DATA;
            core_in_o   <= '0;
            fall_hold   <= gio_pkg::GIO_RST_DATA;
            tx_data     <= gio_pkg::GIO_RST_DATA;
            oe_q        <= gio_pkg::GIO_RST_OE;
            pad_o       <= gio_pkg::GIO_RST_DATA;
            pad_oe_o    <= gio_pkg::GIO_RST_OE;
            pull_up_o   <= gio_pkg::GIO_RST_PULLUP;
            pull_down_o <= gio_pkg::GIO_RST_DATA;
        end else begin
            sync1       <= pad_i;
            sync2       <= sync1;
            sync3       <= sync2;
            pad_level   <= next_pad_level;
            in_clk_q    <= in_clk_i;
            out_clk_q   <= out_clk_i;
            core_in_o   <= next_core_in;
            fall_hold   <= next_fall_hold;
            tx_data     <= next_tx_data;
            oe_q        <= next_oe_q;
            pad_o       <= next_pad;
            pad_oe_o    <= next_pad_oe;
            pull_up_o   <= next_pull_up;
            pull_down_o <= next_pull_down;
        end
    end

    // checks on the cell's own behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence ddr_rx_s;
        rx_active && !serdes_rx && double_edge_mode_i;
    endsequence

    config_pullup_a: assert property (configuring_i |=> pull_up_o && !pull_down_o && !pad_oe_o) // R14
        else $error("pull-up or driver wrong during configuration");
    unused_pull_a: assert property (!configuring_i && mode_i == gio_pkg::GIO_UNUSED |=> // R15
        !pad_oe_o && (pull_up_o == !$past(pull_down_sel_i)))
        else $error("unused pad not released with default pull");
    pull_down_a: assert property (!configuring_i && mode_i == gio_pkg::GIO_UNUSED // R16
        && pull_down_sel_i |=> pull_down_o && !pull_up_o)
        else $error("pull-down selection ignored");
    input_nodrive_a: assert property (mode_i == gio_pkg::GIO_INPUT |=> !pad_oe_o) // R3
        else $error("pad driven in input mode");
    hiz_parked_a: assert property (!pad_oe_o |-> pad_o == 1'b0) // R19
        else $error("pad data not parked while undriven");
    clkout_drive_a: assert property (!configuring_i && mode_i == gio_pkg::GIO_CLKOUT // R12
        |=> pad_oe_o && pad_o == $past(out_clk_i))
        else $error("clock not driven in clock-output mode");
    alt_direct_a: assert property (alt_sel_i |-> alternate_pad_path_o == pad_i) // R4
        else $error("alternate path not direct");
    rise_sample_a: assert property (ddr_rx_s ##0 in_rise |=> core_in_o[0] == $past(pad_level)) // R17
        else $error("rising sample missing on bit 0");
    fall_sample_a: assert property (ddr_rx_s ##0 in_fall && !ddr_resync_i // R6
        |=> core_in_o[1] == $past(pad_level))
        else $error("falling sample missing on bit 1");
    resync_delay_a: assert property (ddr_rx_s ##0 in_fall && ddr_resync_i // R18
        ##[1:300] (rx_active && in_rise && double_edge_mode_i && ddr_resync_i)
        |=> core_in_o[1] == $past(fall_hold))
        else $error("resync falling sample not released on rise");
    invert_out_a: assert property (!configuring_i && mode_i == gio_pkg::GIO_OUTPUT && !serdes_tx // R8
        && !double_edge_mode_i && !out_reg_en_i && core_oe_i
        |=> pad_oe_o && pad_o == ($past(core_out_i[0]) ^ $past(out_invert_i)))
        else $error("output inversion wrong");
endmodule // gio_cell

`default_nettype wire

/* File: core/gio_pkg.sv */
// shared modes and constants of the general-purpose pad cell logic
package gio_pkg;
    // pad cell operating modes
    typedef enum logic [2:0] {
        GIO_UNUSED,
        GIO_INPUT,
        GIO_OUTPUT,
        GIO_BIDIR,
        GIO_CLKOUT
    } gio_mode_t;

    localparam int          GIO_CLK_MHZ      = 25;       // system clock rate
    localparam int          GIO_SERDES_WIDTH = 4;        // one-to-four serializer ratio
    localparam int          GIO_CORE_WIDTH   = 4;        // core-side data bits
    localparam logic        GIO_RST_OE       = 1'b0;     // driver off at reset
    localparam logic        GIO_RST_PULLUP   = 1'b1;     // weak pull-up at reset
    localparam logic        GIO_RST_DATA     = 1'b0;     // data registers at reset
    localparam logic [1:0]  GIO_RST_COUNT    = 2'h0;     // serdes bit counter at reset
endpackage : gio_pkg

/* File: core/gio_serdes.sv */
// one-to-four deserializer and four-to-one serializer of the high-speed pad cell
`timescale 1ns/1ps
`default_nettype none

module gio_serdes #(
    parameter int W = gio_pkg::GIO_SERDES_WIDTH
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // receive side
    input  wire logic         shift_in_i,
    input  wire logic         in_bit_i,
    output logic [W-1:0]      par_o,
    // transmit side
    input  wire logic         shift_out_i,
    input  wire logic [W-1:0] par_i,
    output logic              ser_o
);
    logic [W-1:0]         in_shift;
    logic [W-1:0]         next_in_shift;
    logic [W-1:0]         next_par;
    logic [$clog2(W)-1:0] in_cnt;
    logic [$clog2(W)-1:0] next_in_cnt;
    logic [W-1:0]         out_shift;
    logic [W-1:0]         next_out_shift;
    logic [$clog2(W)-1:0] out_cnt;
    logic [$clog2(W)-1:0] next_out_cnt;
    logic                 next_ser;

    // first bit received lands in bit 0, last in bit W-1
    always_comb begin
        next_in_shift  = in_shift;
        next_in_cnt    = in_cnt;
        next_par       = par_o;
        next_out_shift = out_shift;
        next_out_cnt   = out_cnt;
        next_ser       = ser_o;
        if (shift_in_i) begin
            next_in_shift = {in_bit_i, in_shift[W-1:1]};
            next_in_cnt   = in_cnt + 1'b1;
            if (in_cnt == ($clog2(W))'(W - 1)) begin
                next_par = {in_bit_i, in_shift[W-1:1]};
            end
        end
        // a fresh word is loaded every W shifts, bit 0 goes out first
        if (shift_out_i) begin
            next_out_cnt = out_cnt + 1'b1;
            if (out_cnt == '0) begin
                next_ser       = par_i[0];
                next_out_shift = par_i >> 1;
            end else begin
                next_ser       = out_shift[0];
                next_out_shift = out_shift >> 1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            in_shift  <= '0;
            in_cnt    <= '0;
            par_o     <= '0;
            out_shift <= '0;
            out_cnt   <= '0;
            ser_o     <= gio_pkg::GIO_RST_DATA;
        end else begin
            in_shift  <= next_in_shift;
            in_cnt    <= next_in_cnt;
            par_o     <= next_par;
            out_shift <= next_out_shift;
            out_cnt   <= next_out_cnt;
            ser_o     <= next_ser;
        end
    end
endmodule // gio_serdes

`default_nettype wire

/* File: dv/gio_pad_model.sv */
// board-side model of the signal level seen at the pad
`timescale 1ns/1ps
`default_nettype none

module gio_pad_model (
    // clock
    input  wire logic clk_i,
    // cell pad side
    input  wire logic cell_pad_i,
    input  wire logic cell_oe_i,
    input  wire logic cell_pull_up_i,
    input  wire logic cell_pull_down_i,
    // board source steered by the bench
    input  wire logic ext_drive_i,
    input  wire logic ext_val_i,
    // resolved pad level
    output logic      pad_level_o
);
    logic churn = 1'h0;

    // a floating unpulled line has no level, so show one that changes every cycle
    always @(posedge clk_i) begin
        churn <= ~churn;
    end

    // resolve the wire: cell driver first, then the board, then the weak pulls
    always_comb begin
        if (cell_oe_i) begin
            pad_level_o = cell_pad_i;
        end else if (ext_drive_i) begin
            pad_level_o = ext_val_i;
        end else if (cell_pull_up_i) begin
            pad_level_o = 1'h1;
        end else if (cell_pull_down_i) begin
            pad_level_o = 1'h0;
        end else begin
            pad_level_o = churn;
        end
    end
endmodule // gio_pad_model

`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench of the pad cell register logic
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int CW = gio_pkg::GIO_CORE_WIDTH;
    // design inputs
    logic clk_i, resetn_i, configuring_i, in_reg_en_i, in_fall_edge_i, out_reg_en_i;
    logic out_fall_edge_i, oe_fall_edge_i, out_invert_i, double_edge_mode_i, ddr_resync_i;
    logic serdes_en_i, alt_sel_i, pull_down_sel_i, in_clk_i, out_clk_i, core_oe_i;
    logic ext_drive, ext_val;
    logic [CW-1:0] core_out_i;
    gio_pkg::gio_mode_t mode_i;
    // design outputs
    logic [CW-1:0] core_in_o;
    logic alternate_pad_path_o, pad_i, pad_o, pad_oe_o, pull_up_o, pull_down_o;
    int errors = 0;
    int checks = 0;
    int cycles = 0;

    gio_cell #(.HIGH_SPEED(1'h1), .CW(CW)) gio_cell_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .configuring_i(configuring_i), .mode_i(mode_i),
        .in_reg_en_i(in_reg_en_i), .in_fall_edge_i(in_fall_edge_i),
        .out_reg_en_i(out_reg_en_i), .out_fall_edge_i(out_fall_edge_i),
        .oe_fall_edge_i(oe_fall_edge_i), .out_invert_i(out_invert_i),
        .double_edge_mode_i(double_edge_mode_i), .ddr_resync_i(ddr_resync_i),
        .serdes_en_i(serdes_en_i), .alt_sel_i(alt_sel_i), .pull_down_sel_i(pull_down_sel_i),
        .in_clk_i(in_clk_i), .out_clk_i(out_clk_i), .core_out_i(core_out_i),
        .core_oe_i(core_oe_i), .core_in_o(core_in_o),
        .alternate_pad_path_o(alternate_pad_path_o), .pad_i(pad_i), .pad_o(pad_o),
        .pad_oe_o(pad_oe_o), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o));

    gio_pad_model gio_pad_model_inst (
        .clk_i(clk_i), .cell_pad_i(pad_o), .cell_oe_i(pad_oe_o), .cell_pull_up_i(pull_up_o),
        .cell_pull_down_i(pull_down_o), .ext_drive_i(ext_drive), .ext_val_i(ext_val),
        .pad_level_o(pad_i));

    // 25 MHz system clock
    initial begin
        clk_i = 1'h0;
        forever #20 clk_i = ~clk_i;
    end

    // driving and sampling happens 1 ns after a rising edge, except in the alternate-path steps, which drive and check 2 and 3 ns after one
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_word(input logic [CW-1:0] got, input logic [CW-1:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // a tree clock level change is seen and registered by the cell one edge later, serdes results one after
    task automatic in_edge(input logic lvl);
        in_clk_i = lvl;
        tick(2);
    endtask

    task automatic out_edge(input logic lvl);
        out_clk_i = lvl;
        tick(2);
    endtask

    // the pad level passes a synchroniser and filter of four cycles before use
    task automatic pad_set(input logic v);
        ext_val = v;
        tick(6);
    endtask

    // quiet configuration, then a two-cycle reset so counters start aligned
    task automatic restart(input gio_pkg::gio_mode_t m);
        {configuring_i, in_reg_en_i, in_fall_edge_i, out_reg_en_i} = 4'h0;
        {out_fall_edge_i, oe_fall_edge_i, out_invert_i, double_edge_mode_i} = 4'h0;
        {ddr_resync_i, serdes_en_i, alt_sel_i, pull_down_sel_i} = 4'h0;
        {in_clk_i, out_clk_i, core_oe_i, ext_drive, ext_val} = 5'h02;
        core_out_i = 4'h0;
        mode_i = m;
        resetn_i = 1'h0;
        tick(2);
        resetn_i = 1'h1;
        tick(2);
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // hang guard, far above the fewer than two hundred cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            $display("BAD %0t run did not finish in time", $time);
            print_verdict();
        end
    end

    initial begin
        resetn_i = 1'h0;
        restart(gio_pkg::GIO_UNUSED);
        chk_bit(pad_oe_o, 1'h0, "unused driver");
        chk_bit(pull_up_o, 1'h1, "unused pull up");
        chk_word(core_in_o, 4'h0, "core data at reset");
        pull_down_sel_i = 1'h1;
        tick(2);
        chk_bit(pull_down_o, 1'h1, "pull down chosen");
        chk_bit(pull_up_o, 1'h0, "pull up dropped");
        // configuration overrides an active output
        mode_i = gio_pkg::GIO_OUTPUT;
        {core_oe_i, core_out_i} = 5'h11;
        configuring_i = 1'h1;
        tick(2);
        chk_bit(pull_up_o, 1'h1, "configuring pull up");
        chk_bit(pad_oe_o, 1'h0, "configuring driver");
        // unregistered output, inversion and enable
        restart(gio_pkg::GIO_OUTPUT);
        {core_oe_i, core_out_i} = 5'h11;
        tick(2);
        chk_bit(pad_oe_o, 1'h1, "driver on");
        chk_bit(pad_o, 1'h1, "plain data");
        out_invert_i = 1'h1;
        tick(2);
        chk_bit(pad_o, 1'h0, "inverted data");
        {out_invert_i, core_oe_i} = 2'h0;
        tick(2);
        chk_bit(pad_oe_o, 1'h0, "driver off");
        chk_bit(pad_o, 1'h0, "data when off");
        // registered output, rising then falling edge
        restart(gio_pkg::GIO_OUTPUT);
        {out_reg_en_i, core_oe_i, core_out_i} = 6'h31;
        tick(2);
        chk_bit(pad_o, 1'h0, "no edge yet");
        out_edge(1'h1);
        chk_bit(pad_o, 1'h1, "rise launch");
        chk_bit(pad_oe_o, 1'h1, "enable registered");
        core_out_i = 4'h0;
        out_edge(1'h0);
        chk_bit(pad_o, 1'h1, "fall ignored");
        out_fall_edge_i = 1'h1;
        out_edge(1'h1);
        chk_bit(pad_o, 1'h1, "rise ignored");
        out_edge(1'h0);
        chk_bit(pad_o, 1'h0, "fall launch");
        {oe_fall_edge_i, core_oe_i} = 2'h2;
        out_edge(1'h1);
        chk_bit(pad_oe_o, 1'h1, "enable waits for fall");
        out_edge(1'h0);
        chk_bit(pad_oe_o, 1'h0, "enable taken on fall");
        // double-edge output
        restart(gio_pkg::GIO_OUTPUT);
        {out_reg_en_i, double_edge_mode_i, core_oe_i, core_out_i} = 7'h72;
        out_edge(1'h1);
        chk_bit(pad_o, 1'h0, "rise bit");
        out_edge(1'h0);
        chk_bit(pad_o, 1'h1, "fall bit");
        // clock output ignores inversion
        restart(gio_pkg::GIO_CLKOUT);
        out_invert_i = 1'h1;
        out_edge(1'h1);
        chk_bit(pad_oe_o, 1'h1, "clock driver");
        chk_bit(pad_o, 1'h1, "clock high");
        out_edge(1'h0);
        chk_bit(pad_o, 1'h0, "clock low");
        // registered input, rising then falling select
        restart(gio_pkg::GIO_INPUT);
        {in_reg_en_i, ext_drive} = 2'h3;
        pad_set(1'h1);
        chk_word(core_in_o, 4'h0, "no capture edge");
        in_edge(1'h1);
        chk_word(core_in_o, 4'h1, "rise capture");
        in_fall_edge_i = 1'h1;
        pad_set(1'h0);
        in_edge(1'h0);
        chk_word(core_in_o, 4'h0, "fall capture");
        // alternate path is combinational; held across an edge so the cell's check sees it
        alt_sel_i = 1'h1;
        ext_val = 1'h1;
        #1;
        chk_bit(alternate_pad_path_o, 1'h1, "alternate follows pad");
        ext_val = 1'h0;
        #1;
        chk_bit(alternate_pad_path_o, 1'h0, "alternate follows low");
        ext_val = 1'h1;
        tick(1);
        alt_sel_i = 1'h0;
        #1;
        chk_bit(alternate_pad_path_o, 1'h0, "alternate off");
        // double-edge input, normal then resync
        restart(gio_pkg::GIO_INPUT);
        {in_reg_en_i, double_edge_mode_i, ext_drive} = 3'h7;
        in_edge(1'h1);
        pad_set(1'h1);
        in_edge(1'h0);
        chk_word({2'h0, core_in_o[1:0]}, 4'h2, "two streams");
        restart(gio_pkg::GIO_INPUT);
        {in_reg_en_i, double_edge_mode_i, ddr_resync_i, ext_drive} = 4'hf;
        in_edge(1'h1);
        pad_set(1'h1);
        in_edge(1'h0);
        chk_word({2'h0, core_in_o[1:0]}, 4'h0, "fall sample held");
        pad_set(1'h0);
        in_edge(1'h1);
        chk_word({2'h0, core_in_o[1:0]}, 4'h2, "released on rise");
        // deserializer, first bit on bit 0
        restart(gio_pkg::GIO_INPUT);
        {in_reg_en_i, serdes_en_i, ext_drive} = 3'h7;
        for (int i = 0; i < 4; i++) begin
            pad_set(i != 1);
            in_edge(1'h1);
            in_edge(1'h0);
        end
        chk_word(core_in_o, 4'hd, "deserialized word");
        // serializer, bit 0 leaves first, one bit per output rise
        restart(gio_pkg::GIO_OUTPUT);
        {serdes_en_i, core_oe_i, core_out_i} = 6'h3b;
        for (int i = 0; i < 4; i++) begin
            out_edge(1'h1);
            chk_bit(pad_o, core_out_i[i], "serial bit");
            out_edge(1'h0);
        end
        // bidirectional: unregistered transmit loops back into registered receive
        restart(gio_pkg::GIO_BIDIR);
        {in_reg_en_i, core_oe_i, core_out_i} = 6'h31;
        tick(6);
        chk_bit(pad_o, 1'h1, "bidir transmit");
        chk_word(core_in_o, 4'h0, "bidir awaits edge");
        in_edge(1'h1);
        chk_word(core_in_o, 4'h1, "bidir receive");
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
